// ===== rtl/flash_iap_pkg.sv
package flash_iap_pkg;

  // Register byte addresses
  localparam logic [7:0] OFF_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_DATA_LOW = 8'h10;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h14;
  localparam logic [7:0] OFF_UNLOCK_BASE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // Control zero field positions
  localparam int MODE_LSB = 4;
  localparam int BIT_ENABLED = 3;
  localparam int BIT_ARM = 2;
  localparam int BIT_TRIG = 1;
  localparam int BIT_RDTRIG = 0;
  // Control two field positions
  localparam int BIT_TIMESEL = 0;
  localparam int BIT_RDEN = 1;
  localparam int BIT_CLEAR = 2;

  // Mode encodings
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  // Unlock pattern, six bytes in register order
  localparam logic [47:0] UNLOCK_PATTERN = 48'h00_0D_C3_04_09_40;

  // Timing
  localparam int CLK_NS = 25;
  localparam int READ_INSTR_CYCLES = 3;
  localparam int INSTR_NS = 100;
  localparam int READ_CYCLES = (READ_INSTR_CYCLES * INSTR_NS + CLK_NS - 1)
    / CLK_NS;
  localparam int PROG_SHORT_US = 2000;
  localparam int PROG_LONG_US = 3000;
  localparam int UNLOCK_US = 100;
  localparam int PROG_SHORT_CYC = PROG_SHORT_US * 1000 / CLK_NS;
  localparam int PROG_LONG_CYC = PROG_LONG_US * 1000 / CLK_NS;
  localparam int UNLOCK_CYC = UNLOCK_US * 1000 / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE,
    ST_READ
  } seq_state_t;

endpackage : flash_iap_pkg

// ===== rtl/flash_iap_program_read_sequencer.sv
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module flash_iap_program_read_sequencer
  import flash_iap_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int ADDR_BITS = 12,
  parameter int PROG_SHORT = PROG_SHORT_CYC,
  parameter int PROG_LONG = PROG_LONG_CYC,
  parameter int UNLOCK_TIME = UNLOCK_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU stall
  output logic cpuStall
);

  localparam int OFS_BITS = $clog2(WORDS);
  localparam int PAGE_BITS = ADDR_BITS - OFS_BITS;
  localparam int PAGES = 1 << PAGE_BITS;
  localparam int CNT_BITS = 32;

  // Refuse sizes that the decode and storage cannot serve
  if (WORDS != 32 || ADDR_BITS < 9 || ADDR_BITS > 16 ||
      PROG_SHORT < 1 || PROG_LONG < 1 ||
      UNLOCK_TIME < 1) begin : g_badParams
    $error("flash_iap: unsupported parameters");
  end

  // Flash array and write buffer storage
  logic [15:0] flashMem [PAGES*WORDS];
  logic [15:0] bufData [WORDS];
  logic [WORDS-1:0] bufValid_r;

  // Registers
  logic [2:0] mode_r;
  logic enabled_r, arm_r, trig_r, rdTrig_r;
  logic timeSel_r, rdEn_r;
  logic [ADDR_BITS-1:0] addr_r;
  logic [7:0] dataLow_r, dataHigh_r;
  logic [7:0] unlock_r [6];
  logic [5:0] unlockSeen_r;
  logic [CNT_BITS-1:0] cnt_r, armCnt_r;
  seq_state_t state_r;

  // Bus state
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  // Write acceptance and decode
  wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire [7:0] wA = awAddr_r;
  wire wrCtrl0 = doWrite && wA == OFF_CTRL_ZERO && wStrb_r[0];
  wire wrCtrl2 = doWrite && wA == OFF_CTRL_TWO && wStrb_r[0];
  wire wrAddrL = doWrite && wA == OFF_ADDR_LOW && wStrb_r[0];
  wire wrAddrH = doWrite && wA == OFF_ADDR_HIGH && wStrb_r[0];
  wire wrDataL = doWrite && wA == OFF_DATA_LOW && wStrb_r[0];
  wire wrDataH = doWrite && wA == OFF_DATA_HIGH && wStrb_r[0];
  wire wrHit = wA <= OFF_STATUS && wA[1:0] == 2'b00;
  wire [7:0] wByte = wData_r[7:0];
  wire [2:0] wMode = wByte[MODE_LSB+:3];
  wire [OFS_BITS-1:0] ofs = addr_r[OFS_BITS-1:0];
  wire [PAGE_BITS-1:0] page = addr_r[ADDR_BITS-1:OFS_BITS];
  wire idle = state_r == ST_IDLE;

  // Start conditions; erase and program need the enabled flag
  wire goProg = wrCtrl0 && wByte[BIT_TRIG] && idle && enabled_r &&
    wMode == MODE_WRITE && mode_r == MODE_WRITE;
  wire goErase = wrCtrl0 && wByte[BIT_TRIG] && idle && enabled_r &&
    wMode == MODE_ERASE && mode_r == MODE_ERASE;
  wire goRead = wrCtrl0 && wByte[BIT_RDTRIG] && idle && rdEn_r &&
    wMode == MODE_READ && mode_r == MODE_READ;
  wire goArm = wrCtrl0 && wByte[BIT_ARM] && wMode == MODE_UNLOCK;
  wire [CNT_BITS-1:0] progLen = timeSel_r ? CNT_BITS'(PROG_LONG) :
    CNT_BITS'(PROG_SHORT);
  wire cntDone = cnt_r == '0;
  wire patternOk = &unlockSeen_r &&
    {unlock_r[0], unlock_r[1], unlock_r[2], unlock_r[3], unlock_r[4],
     unlock_r[5]} == UNLOCK_PATTERN;

  // Read decode
  wire [7:0] rA = s_axi_araddr;
  logic [31:0] rVal;
  always_comb begin
    rVal = 32'h0000_0000;
    unique case (rA)
      OFF_CTRL_ZERO: rVal = {24'h0, 1'b0, mode_r, enabled_r, arm_r,
        trig_r, rdTrig_r};
      OFF_CTRL_TWO: rVal = {29'h0, 1'b0, rdEn_r, timeSel_r};
      OFF_ADDR_LOW: rVal = {24'h0, addr_r[7:0]};
      OFF_ADDR_HIGH: rVal = {24'h0, 8'(addr_r[ADDR_BITS-1:8])};
      OFF_DATA_LOW: rVal = {24'h0, dataLow_r};
      OFF_DATA_HIGH: rVal = {24'h0, dataHigh_r};
      OFF_STATUS: rVal = {24'h0, 5'h0, cpuStall, 2'(state_r)};
      default: rVal = 32'h0000_0000;
    endcase
  end
  wire rdHit = (rA <= OFF_STATUS && rA[1:0] == 2'b00);

  // AXI write handshake: hold address and data until both arrive
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clkEn) begin
      s_axi_awready <= !awHeld_r && !s_axi_awready;
      s_axi_wready <= !wHeld_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end

  // AXI read: one cycle after address acceptance
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rVal;
        s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control, address, data and unlock registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_WRITE;
      enabled_r <= 1'b0;
      arm_r <= 1'b0;
      timeSel_r <= 1'b0;
      rdEn_r <= 1'b0;
      addr_r <= '0;
      dataLow_r <= 8'h00;
      dataHigh_r <= 8'h00;
      unlockSeen_r <= 6'h00;
      armCnt_r <= '0;
      for (int i = 0; i < 6; i++) begin
        unlock_r[i] <= 8'h00;
      end
    end else if (clkEn) begin
      if (wrCtrl0) begin
        mode_r <= wMode;
        if (!wByte[BIT_ENABLED]) begin
          enabled_r <= 1'b0;
        end
      end
      if (goArm) begin
        arm_r <= 1'b1;
        armCnt_r <= CNT_BITS'(UNLOCK_TIME);
        unlockSeen_r <= 6'h00;
      end else if (arm_r) begin
        if (armCnt_r == '0) begin
          arm_r <= 1'b0;
        end else begin
          armCnt_r <= armCnt_r - 1'b1;
        end
        if (patternOk) begin
          enabled_r <= 1'b1;
        end
      end
      if (wrCtrl2) begin
        timeSel_r <= wByte[BIT_TIMESEL];
        rdEn_r <= wByte[BIT_RDEN];
      end
      for (int i = 0; i < 6; i++) begin
        if (doWrite && wStrb_r[0] &&
            wA == OFF_UNLOCK_BASE + 8'(4 * i)) begin
          unlock_r[i] <= wByte;
          unlockSeen_r[i] <= arm_r;
        end
      end
      if (wrAddrL) begin
        addr_r[7:0] <= wByte;
      end else if (wrAddrH) begin
        addr_r[ADDR_BITS-1:8] <= wByte[ADDR_BITS-9:0];
      end else if (wrDataH && idle && ofs != '1) begin
        addr_r <= addr_r + 1'b1;
      end
      if (wrDataL) begin
        dataLow_r <= wByte;
      end
      if (wrDataH) begin
        dataHigh_r <= wByte;
      end
      if (state_r == ST_READ && cntDone) begin
        {dataHigh_r, dataLow_r} <= flashMem[addr_r];
      end
    end
  end

  // Write buffer: high byte commits, clear bit empties it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bufValid_r <= '0;
    end else if (clkEn) begin
      if (wrCtrl2 && wByte[BIT_CLEAR]) begin
        bufValid_r <= '0;
      end else if (wrDataH && idle) begin
        bufValid_r[ofs] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && wrDataH && idle) begin
      bufData[ofs] <= {wByte, dataLow_r};
    end
  end

  // Sequencer: triggers set by software, cleared by hardware
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      trig_r <= 1'b0;
      rdTrig_r <= 1'b0;
      cnt_r <= '0;
      cpuStall <= 1'b0;
    end else if (clkEn) begin
      unique case (state_r)
        ST_IDLE: begin
          if (goProg || goErase) begin
            state_r <= goProg ? ST_PROG : ST_ERASE;
            trig_r <= 1'b1;
            cnt_r <= progLen - 1'b1;
            cpuStall <= 1'b1;
          end else if (goRead) begin
            state_r <= ST_READ;
            rdTrig_r <= 1'b1;
            cnt_r <= CNT_BITS'(READ_CYCLES - 1);
            cpuStall <= 1'b1;
          end
        end
        ST_PROG, ST_ERASE, ST_READ: begin
          if (cntDone) begin
            state_r <= ST_IDLE;
            trig_r <= 1'b0;
            rdTrig_r <= 1'b0;
            cpuStall <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Array update at the end of erase or program
  always_ff @(posedge ref_clk) begin
    if (clkEn && cntDone && state_r == ST_ERASE) begin
      for (int i = 0; i < WORDS; i++) begin
        flashMem[{page, OFS_BITS'(i)}] <= 16'h0000;
      end
    end else if (clkEn && cntDone && state_r == ST_PROG) begin
      for (int i = 0; i < WORDS; i++) begin
        if (bufValid_r[i]) begin
          flashMem[{page, OFS_BITS'(i)}] <= bufData[i];
        end
      end
    end
  end

endmodule : flash_iap_program_read_sequencer

// ===== tb/flash_iap_chk.sv
`timescale 1ns/1ps
module flash_iap_chk
  import flash_iap_pkg::*;
#(
  parameter int PROG_SHORT = 20,
  parameter int PROG_LONG = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Bus
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stall
  input wire logic cpuStall
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int stallCnt_r;
  // Enabled cycles spent in the current stall
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) stallCnt_r <= 0;
    else if (clkEn) stallCnt_r <= cpuStall ? stallCnt_r + 1 : 0;
  end
  sequence stallRun;
    cpuStall [*8];
  endsequence
  a_stall_length: assert property ($fell(cpuStall) |-> stallCnt_r inside
    {READ_CYCLES, PROG_SHORT, PROG_LONG}) else $error("bad stall length");
  a_stall_floor: assert property ($rose(cpuStall) |-> stallRun)
    else $error("stall too short");
  a_stall_cause: assert property ($rose(cpuStall) |-> s_axi_bvalid)
    else $error("stall without a write");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("stray rvalid");
  a_bresp_code: assert property (s_axi_bvalid |->
    s_axi_bresp inside {2'b00, 2'b10}) else $error("bad bresp");
  a_rdata_narrow: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid held after accept");
  a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid held after accept");
endmodule : flash_iap_chk
bind flash_iap_program_read_sequencer flash_iap_chk #(
  .PROG_SHORT(PROG_SHORT), .PROG_LONG(PROG_LONG)) chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpuStall(cpuStall));

// ===== tb/cpu_master.sv
`timescale 1ns/1ps
module cpu_master (
  // Clock and stall
  input wire logic ref_clk,
  input wire logic cpuStall,
  // Write side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Bus idle at time zero
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // Store; the core issues nothing while stalled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    while (cpuStall !== 1'b0) @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  // Load
  task automatic rd(input logic [7:0] a);
    while (cpuStall !== 1'b0) @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
endmodule : cpu_master

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); \
  end \
end
module tb
  import flash_iap_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bx;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, cpuStall;
  logic [1:0] bQ[$];
  logic [33:0] rQ[$];
  logic [33:0] rx;
  logic [6:0] pg;
  logic [15:0] d0, d1, d2;
  int failures = 0;
  int cmp_count = 0;
  int runLen = 0;
  int lastLen = 0;
  int cycles = 0;

  flash_iap_program_read_sequencer #(.PROG_SHORT(20), .PROG_LONG(30),
    .UNLOCK_TIME(50)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpuStall(cpuStall));
  cpu_master m (
    .ref_clk(ref_clk), .cpuStall(cpuStall),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  always #12.5 ref_clk = ~ref_clk;

  // Answers are matched against the oldest note
  always @(posedge ref_clk) begin
    if ((s_axi_bvalid && s_axi_bready) === 1'b1) begin
      bx = bQ.pop_front();
      `CHK(s_axi_bresp, bx)
    end
    if ((s_axi_rvalid && s_axi_rready) === 1'b1) begin
      rx = rQ.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, rx)
    end
  end

  // Length of the most recent stall
  always @(posedge ref_clk) begin
    if (cpuStall === 1'b1) runLen <= runLen + 1;
    else if (runLen != 0) begin
      lastLen <= runLen;
      runLen <= 0;
    end
  end

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    bQ.push_back(2'b00);
    m.wr(a, d);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [33:0] e);
    rQ.push_back(e);
    m.rd(a);
  endtask : r
  task automatic idle();
    repeat (3) @(posedge ref_clk);
    while (cpuStall !== 1'b0) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask : idle
  task automatic setA(input logic [11:0] a);
    w(OFF_ADDR_LOW, a[7:0]);
    w(OFF_ADDR_HIGH, {4'h0, a[11:8]});
  endtask : setA
  task automatic word(input logic [15:0] v);
    w(OFF_DATA_LOW, v[7:0]);
    w(OFF_DATA_HIGH, v[15:8]);
  endtask : word
  // Fetch one flash word and compare both data bytes
  task automatic peek(input logic [11:0] a, input logic [15:0] e);
    setA(a);
    w(OFF_CTRL_ZERO, 8'h38);
    w(OFF_CTRL_ZERO, 8'h39);
    idle();
    `CHK(lastLen, READ_CYCLES)
    r(OFF_DATA_LOW, {26'h0, e[7:0]});
    r(OFF_DATA_HIGH, {26'h0, e[15:8]});
  endtask : peek

  initial begin
    void'($urandom(30));
    pg = 7'($urandom);
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    r(OFF_STATUS, 34'h0);
    r(OFF_CTRL_ZERO, 34'h0);
    r(8'h34, {2'b10, 32'h0});
    // Unmapped offset refuses a write with an error code
    bQ.push_back(2'b10);
    m.wr(8'h34, 8'hFF);
    w(OFF_CTRL_ZERO, 8'h08);
    w(OFF_CTRL_ZERO, 8'h0A);
    idle();
    r(OFF_CTRL_ZERO, 34'h0);
    w(OFF_CTRL_ZERO, 8'h64);
    for (int i = 0; i < 6; i++)
      w(OFF_UNLOCK_BASE + 8'(4 * i), UNLOCK_PATTERN[47 - 8 * i -: 8]);
    repeat (60) @(posedge ref_clk);
    r(OFF_CTRL_ZERO, 34'h68);
    setA({pg, 5'h1E});
    w(OFF_CTRL_TWO, 8'h06);
    w(OFF_DATA_HIGH, 8'h00);
    w(OFF_CTRL_ZERO, 8'h18);
    w(OFF_CTRL_ZERO, 8'h1A);
    idle();
    `CHK(lastLen, 20)
    r(OFF_CTRL_ZERO, 34'h18);
    peek({pg, 5'h1F}, 16'h0000);
    w(OFF_CTRL_ZERO, 8'h08);
    setA({pg, 5'h1D});
    word(16'hA5C3);
    w(OFF_CTRL_TWO, 8'h07);
    setA({pg, 5'h1E});
    word(d0);
    word(d1);
    word(d2);
    w(OFF_CTRL_ZERO, 8'h0A);
    idle();
    `CHK(lastLen, 30)
    r(OFF_CTRL_ZERO, 34'h08);
    w(OFF_CTRL_ZERO, 8'h00);
    w(OFF_CTRL_ZERO, 8'h02);
    idle();
    r(OFF_CTRL_ZERO, 34'h00);
    peek({pg, 5'h1D}, 16'h0000);
    peek({pg, 5'h1E}, d0);
    peek({pg, 5'h1F}, d2);
    // A low clock enable freezes a read and stretches the stall
    setA({pg, 5'h1E});
    w(OFF_CTRL_ZERO, 8'h39);
    clkEn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clkEn <= 1'b1;
    idle();
    `CHK(lastLen, READ_CYCLES + 4)
    r(OFF_DATA_LOW, {26'h0, d0[7:0]});
    r(OFF_DATA_HIGH, {26'h0, d0[15:8]});
    complete_run();
  end
endmodule : tb
